// *** core/fsps_pkg.sv ***
package fsps_pkg;
   localparam int AW = 19;
   localparam int DW = 16;
   localparam int RAW = 5;
   // Software register offsets
   localparam logic [RAW-1:0] R_CTRL  = 5'h00;
   localparam logic [RAW-1:0] R_ADDR  = 5'h04;
   localparam logic [RAW-1:0] R_WDATA = 5'h08;
   localparam logic [RAW-1:0] R_STAT  = 5'h0c;
   localparam logic [RAW-1:0] R_RDATA = 5'h10;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_FAIL = 1;
   localparam int ST_REF  = 2;
   localparam int ST_LOCK = 3;
   localparam int ST_RDY  = 4;
   localparam int ST_CFG  = 5;
   localparam int ST_PWR  = 6;
   localparam int ST_SUSP = 7;
   // Timing
   localparam int CLK_MHZ   = 250;
   localparam int T_WP_NS   = 40;
   localparam int T_ACC_NS  = 70;
   localparam int T_SUSP_US = 20;
   localparam int T_PWR_MS  = 10;
   localparam int WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_CYC    = (T_ACC_NS * CLK_MHZ + 999) / 1000 + 2;
   localparam int SUSP_CYC  = T_SUSP_US * CLK_MHZ;
   localparam int PWR_CYC   = T_PWR_MS * 1000 * CLK_MHZ;
   // Flash addresses and command codes
   localparam logic [AW-1:0] A_UNL1  = 19'h00555;
   localparam logic [AW-1:0] A_UNL2  = 19'h00aaa;
   localparam logic [AW-1:0] A_CFI   = 19'h00055;
   localparam logic [AW-1:0] A_PRB   = 19'h00080;
   localparam logic [7:0]    PRA_LO  = 8'h81;
   localparam logic [7:0]    PRA_HI  = 8'h84;
   localparam logic [7:0]    D_AA    = 8'haa;
   localparam logic [7:0]    D_55    = 8'h55;
   localparam logic [7:0]    D_PROG  = 8'ha0;
   localparam logic [7:0]    D_SUSP  = 8'hb0;
   localparam logic [7:0]    D_RES   = 8'h30;
   localparam logic [7:0]    D_IDEN  = 8'h90;
   localparam logic [7:0]    D_IDEX  = 8'hf0;
   localparam logic [7:0]    D_PR    = 8'hc0;
   localparam logic [7:0]    D_CFG   = 8'hd0;
   localparam logic [7:0]    D_CFI   = 8'h98;
   localparam logic [7:0]    D_LOCK  = 8'h00;

   typedef enum logic [3:0] {
      C_READ = 4'h0, C_PROG = 4'h1, C_SUSP = 4'h2, C_RES = 4'h3,
      C_IDEN = 4'h4, C_IDEX = 4'h5, C_PRPROG = 4'h6, C_PRLOCK = 4'h7,
      C_BSTAT = 4'h8, C_SETCFG = 4'h9, C_CFI = 4'ha
   } fsps_cmd_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_WSET = 3'b001, S_WPUL = 3'b010, S_WREC = 3'b011,
      S_RPUL = 3'b100, S_RCAP = 3'b101, S_WAIT = 3'b110
   } fsps_state_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] dq;
      logic          dq_oe;
      logic          ce_n;
      logic          oe_n;
      logic          we_n;
   } fsps_pins_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
   } fsps_cyc_t;
endpackage

// *** core/fsps_host.sv ***
// What this block does
// RULE_01: Suspend halts programming within 20 us; host waits that long afterward.
// RULE_02: While programming is suspended, other sectors read as normal array data.
// RULE_03: Suspend and resume are single writes, address ignored, shared with erase.
// RULE_04: Identification codes match for pin and software entry methods.
// RULE_05: Protection register is 128 bits in two 64-bit blocks A and B.
// RULE_06: Block A holds a factory number and can never be changed.
// RULE_07: Block B data is written by the four-cycle protection program sequence.
// RULE_08: Block B lock is four cycles with block_lock_flag zero in the last.
// RULE_09: Block B status query reads block_lock_flag low when locked.
// RULE_10: Protection register reads follow the identification entry sequence.
// RULE_11: Identification exit must follow protection reads or block B status query.
// RULE_12: Open-drain completion output stays low during internal program or erase.
// RULE_13: One write of 98h at 55h enters CFI query mode.
// RULE_14: CFI query is accepted from read state or identification mode.
// RULE_15: CFI mode lasts until the identification exit command.
// RULE_16: Write cycles are inhibited with output gate low, select high, strobe high.
// RULE_17: Programming is allowed only about 10 ms after power-on.
// RULE_18: failure_status_bit rises on timeout or protected-sector program or erase.
// RULE_19: After failure_status_bit is seen, recheck the toggle bit once more.
// RULE_20: Erase-suspended sector reads give fixed status with completion released.
// RULE_21: Programming during erase suspend reports normal status with toggling line 2.
// RULE_22: Program-suspended sector reads give fixed status with completion released.
// RULE_23: Both suspended, other sectors return true data, completion released.
// RULE_24: Configuration 00 polling gives complement of bit 7 while programming.
// RULE_25: Configuration 01 poll_status_bit is low while busy, high when done.
// RULE_26: alternating_status_bit alternates on reads while an operation is active.
// RULE_27: Configuration 00 returns to read mode; 01 waits for identification exit.
module fsps_host
   import fsps_pkg::*;
#(
   parameter int P_SUSP = fsps_pkg::SUSP_CYC,
   parameter int P_PWR  = fsps_pkg::PWR_CYC
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Software port
   input  wire logic [fsps_pkg::RAW-1:0] sw_addr,
   input  wire logic [31:0]            sw_wdata,
   input  wire logic                   sw_wr,
   input  wire logic                   sw_rd,
   output logic      [31:0]            sw_rdata,
   // Flash pins
   output fsps_pkg::fsps_pins_t        fl_o,
   input  wire logic [fsps_pkg::DW-1:0] fl_dq_i,
   input  wire logic                   fl_rdy_i
);
   import fsps_pkg::*;

   localparam int CW = 22;
   if (P_SUSP < 1 || P_PWR < 1 || P_SUSP >= 2**CW || P_PWR >= 2**CW
       || WP_CYC < 1) begin : g_bad_param
      $error("fsps_host: counts out of range");
   end

   function automatic logic [2:0] nwr(input fsps_cmd_t c);
      case (c)
         C_READ:                      nwr = 3'h0;
         C_SUSP, C_RES, C_IDEX, C_CFI: nwr = 3'h1;
         C_IDEN, C_BSTAT:             nwr = 3'h3;
         default:                     nwr = 3'h4;
      endcase
   endfunction

   function automatic fsps_cyc_t seq(input fsps_cmd_t c, input logic [2:0] i,
                                     input logic [AW-1:0] a, input logic [DW-1:0] w);
      logic [7:0] code;
      code = D_PROG;
      case (c)
         C_PRPROG, C_PRLOCK: code = D_PR;
         C_IDEN, C_BSTAT:    code = D_IDEN; // RULE_10
         C_SETCFG:           code = D_CFG;
         default:            code = D_PROG;
      endcase
      seq = '{addr: A_UNL1, data: {8'h00, D_AA}};
      if (nwr(c) == 3'h1) begin
         case (c)
            C_SUSP:  seq = '{addr: '0, data: {8'h00, D_SUSP}}; // RULE_03
            C_RES:   seq = '{addr: '0, data: {8'h00, D_RES}}; // RULE_03
            C_CFI:   seq = '{addr: A_CFI, data: {8'h00, D_CFI}}; // RULE_13
            default: seq = '{addr: '0, data: {8'h00, D_IDEX}}; // RULE_15
         endcase
      end else if (i == 3'h1) begin
         seq = '{addr: A_UNL2, data: {8'h00, D_55}};
      end else if (i == 3'h2) begin
         seq = '{addr: A_UNL1, data: {8'h00, code}};
      end else if (i == 3'h3) begin
         case (c)
            C_PRLOCK: seq = '{addr: A_PRB, data: {8'h00, D_LOCK}}; // RULE_08
            C_SETCFG: seq = '{addr: '0, data: {15'h0000, w[0]}};
            default:  seq = '{addr: a, data: w}; // RULE_07
         endcase
      end
   endfunction

   // Pin synchronisers
   logic [DW-1:0] dq_m_q, dq_s_q;
   logic          rdy_m_q, rdy_s_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dq_m_q  <= '0;
         dq_s_q  <= '0;
         rdy_m_q <= 1'b0;
         rdy_s_q <= 1'b0;
      end else begin
         dq_m_q  <= fl_dq_i;
         dq_s_q  <= dq_m_q;
         rdy_m_q <= fl_rdy_i;
         rdy_s_q <= rdy_m_q;
      end
   end

   // Engine state
   fsps_state_t   st_q, st_d;
   fsps_cmd_t     cmd_q, cmd_d;
   fsps_pins_t    pins_q, pins_d;
   fsps_cyc_t     cyc;
   logic [2:0]    idx_q, idx_d;
   logic [CW-1:0] cnt_q, cnt_d, pwr_q, pwr_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [DW-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic          fail_q, fail_d, ref_q, ref_d, lock_q, lock_d, cfg_q, cfg_d;
   logic          susp_q, susp_d, prev_q, prev_d, have_q, have_d, fseen_q, fseen_d;
   logic          pwr_ok_q, pwr_ok_d;
   logic [31:0]   rdata_q, rdata_d;
   logic [7:0]    stat;
   logic          ctrl_wr, prog_type, blk_a;
   fsps_cmd_t     new_cmd;

   assign sw_rdata = rdata_q;
   assign fl_o     = pins_q;
   assign stat     = {susp_q, pwr_ok_q, cfg_q, rdy_s_q, lock_q, ref_q, fail_q,
                      st_q != S_IDLE};

   always_comb begin
      st_d     = st_q;
      cmd_d    = cmd_q;
      idx_d    = idx_q;
      addr_d   = addr_q;
      wdat_d   = wdat_q;
      rdat_d   = rdat_q;
      fail_d   = fail_q;
      ref_d    = ref_q;
      lock_d   = lock_q;
      cfg_d    = cfg_q;
      susp_d   = susp_q;
      prev_d   = prev_q;
      have_d   = have_q;
      fseen_d  = fseen_q;
      pwr_d    = pwr_q;
      pwr_ok_d = pwr_ok_q;
      pins_d   = '{addr: pins_q.addr, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                   we_n: 1'b1};
      cyc       = seq(cmd_q, idx_q, addr_q, wdat_q);
      ctrl_wr   = sw_wr && sw_addr == R_CTRL;
      new_cmd   = fsps_cmd_t'(sw_wdata[3:0]);
      prog_type = new_cmd inside {C_PROG, C_PRPROG, C_PRLOCK};
      blk_a     = addr_q[AW-1:8] == '0 && addr_q[7:0] >= PRA_LO && addr_q[7:0] <= PRA_HI;
      if (!pwr_ok_q) begin
         pwr_d    = pwr_q + 1'b1;
         pwr_ok_d = pwr_q == CW'(P_PWR - 1); // RULE_17
      end
      if (sw_wr && sw_addr == R_ADDR && st_q == S_IDLE) begin
         addr_d = sw_wdata[AW-1:0];
      end
      if (sw_wr && sw_addr == R_WDATA && st_q == S_IDLE) begin
         wdat_d = sw_wdata[DW-1:0];
      end
      unique case (st_q)
         S_IDLE: begin
            if (ctrl_wr) begin
               if (sw_wdata[3:0] > C_CFI || (prog_type && !pwr_ok_q) // RULE_17
                   || (new_cmd == C_PRPROG && blk_a)) begin // RULE_06
                  ref_d = 1'b1;
               end else begin
                  ref_d  = 1'b0;
                  fail_d = 1'b0;
                  cmd_d  = new_cmd;
                  idx_d  = 3'h0;
                  st_d   = (new_cmd == C_READ) ? S_RPUL : S_WSET; // RULE_02
               end
            end
         end
         S_WSET: begin
            pins_d = '{addr: cyc.addr, dq: cyc.data, dq_oe: 1'b1, ce_n: 1'b0,
                       oe_n: 1'b1, we_n: 1'b1};
            st_d   = S_WPUL;
         end
         S_WPUL: begin
            pins_d = '{addr: cyc.addr, dq: cyc.data, dq_oe: 1'b1, ce_n: 1'b0,
                       oe_n: 1'b1, we_n: 1'b0}; // RULE_16
            if (cnt_q == CW'(WP_CYC - 1)) begin
               st_d = S_WREC;
            end
         end
         S_WREC: begin
            if (idx_q + 3'h1 < nwr(cmd_q)) begin
               idx_d = idx_q + 3'h1;
               st_d  = S_WSET;
            end else begin
               st_d = S_IDLE;
               case (cmd_q)
                  C_PROG, C_PRPROG, C_PRLOCK: begin
                     have_d  = 1'b0;
                     fseen_d = 1'b0;
                     st_d    = S_RPUL;
                  end
                  C_SUSP: begin
                     susp_d = 1'b1;
                     st_d   = S_WAIT; // RULE_01
                  end
                  C_RES:    susp_d = 1'b0; // RULE_03
                  C_BSTAT:  st_d = S_RPUL;
                  C_SETCFG: cfg_d = wdat_q[0];
                  default:  st_d = S_IDLE;
               endcase
            end
         end
         S_RPUL: begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            pins_d.addr = (cmd_q inside {C_BSTAT, C_PRLOCK}) ? A_PRB : addr_q;
            if (cnt_q == CW'(RD_CYC - 1)) begin
               st_d = S_RCAP;
            end
         end
         S_RCAP: begin
            st_d = S_RPUL;
            if (cmd_q == C_READ) begin
               rdat_d = dq_s_q;
               st_d   = S_IDLE;
            end else if (cmd_q == C_BSTAT) begin
               rdat_d = dq_s_q;
               lock_d = !dq_s_q[1]; // RULE_09
               cmd_d  = C_IDEX; // RULE_11
               idx_d  = 3'h0;
               st_d   = S_WSET;
            end else if (!have_q) begin
               have_d = 1'b1;
               prev_d = dq_s_q[6];
            end else begin
               prev_d = dq_s_q[6];
               if (dq_s_q[6] == prev_q && rdy_s_q) begin // RULE_26 RULE_12
                  rdat_d = dq_s_q;
                  cmd_d  = C_IDEX;
                  idx_d  = 3'h0;
                  st_d   = cfg_q ? S_WSET : S_IDLE; // RULE_27
               end else if (dq_s_q[6] != prev_q && dq_s_q[5]) begin // RULE_18
                  if (fseen_q) begin
                     fail_d = 1'b1;
                     cmd_d  = C_IDEX;
                     idx_d  = 3'h0;
                     st_d   = S_WSET;
                  end else begin
                     fseen_d = 1'b1; // RULE_19
                  end
               end
            end
         end
         S_WAIT: begin
            if (cnt_q == CW'(P_SUSP - 1)) begin
               st_d = S_IDLE;
            end
         end
         default: st_d = S_IDLE;
      endcase
      if (ctrl_wr && st_q != S_IDLE) begin
         ref_d = 1'b1;
      end
      cnt_d = (st_d != st_q) ? '0 : cnt_q + 1'b1;
      rdata_d = '0;
      if (sw_rd) begin
         case (sw_addr)
            R_CTRL:  rdata_d = {28'h0000000, cmd_q};
            R_ADDR:  rdata_d = {13'h0000, addr_q};
            R_WDATA: rdata_d = {16'h0000, wdat_q};
            R_STAT:  rdata_d = {24'h000000, stat};
            R_RDATA: rdata_d = {16'h0000, rdat_q};
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q     <= S_IDLE;
         cmd_q    <= C_READ;
         idx_q    <= 3'h0;
         cnt_q    <= '0;
         pwr_q    <= '0;
         pwr_ok_q <= 1'b0;
         addr_q   <= '0;
         wdat_q   <= '0;
         rdat_q   <= '0;
         fail_q   <= 1'b0;
         ref_q    <= 1'b0;
         lock_q   <= 1'b0;
         cfg_q    <= 1'b0;
         susp_q   <= 1'b0;
         prev_q   <= 1'b0;
         have_q   <= 1'b0;
         fseen_q  <= 1'b0;
         pins_q   <= '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                       we_n: 1'b1};
         rdata_q  <= '0;
      end else begin
         st_q     <= st_d;
         cmd_q    <= cmd_d;
         idx_q    <= idx_d;
         cnt_q    <= cnt_d;
         pwr_q    <= pwr_d;
         pwr_ok_q <= pwr_ok_d;
         addr_q   <= addr_d;
         wdat_q   <= wdat_d;
         rdat_q   <= rdat_d;
         fail_q   <= fail_d;
         ref_q    <= ref_d;
         lock_q   <= lock_d;
         cfg_q    <= cfg_d;
         susp_q   <= susp_d;
         prev_q   <= prev_d;
         have_q   <= have_d;
         fseen_q  <= fseen_d;
         pins_q   <= pins_d;
         rdata_q  <= rdata_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_write_inhibit: assert property (!fl_o.we_n |-> fl_o.oe_n && !fl_o.ce_n) // RULE_16
      else $error("write strobe low without select or with output gate low");
   a_pwr_gate: assert property (st_q == S_WSET && cmd_q == C_PROG |-> pwr_ok_q) // RULE_17
      else $error("program issued before power-on delay");
   a_susp_code: assert property (st_q == S_WSET && cmd_q == C_SUSP
      |=> fl_o.dq[7:0] == D_SUSP && !fl_o.ce_n) // RULE_03
      else $error("suspend cycle carries wrong code");
   a_cfi_cycle: assert property (st_q == S_WSET && cmd_q == C_CFI
      |=> fl_o.addr == A_CFI && fl_o.dq[7:0] == D_CFI) // RULE_13
      else $error("CFI entry cycle wrong");
   a_lock_flag: assert property (st_q == S_WSET && cmd_q == C_PRLOCK && idx_q == 3'h3
      |=> !fl_o.dq[1]) // RULE_08
      else $error("lock cycle has block_lock_flag set");
   a_blka_refuse: assert property (st_q == S_IDLE && sw_wr && sw_addr == R_CTRL
      && sw_wdata[3:0] == C_PRPROG && addr_q == 19'h00082 |=> ref_q && st_q == S_IDLE) // RULE_06
      else $error("block A program not refused");
   a_bstat_exit: assert property (st_q == S_RCAP && cmd_q == C_BSTAT
      |=> cmd_q == C_IDEX && lock_q == !$past(dq_s_q[1])) // RULE_11
      else $error("status query not followed by exit");
   a_susp_wait: assert property (st_q == S_WREC && cmd_q == C_SUSP && st_d == S_WAIT
      |=> st_q == S_WAIT [*8]) // RULE_01
      else $error("suspend wait cut short");
   a_fail_recheck: assert property (st_q == S_RCAP && have_q && !fseen_q
      && dq_s_q[6] != prev_q && cmd_q == C_PROG |=> !fail_q) // RULE_19
      else $error("failure declared without recheck");
endmodule // fsps_host

// *** verif/fsps_flash_model.sv ***
module fsps_flash_model
   import fsps_pkg::*;
#(
   parameter int          P_BUSY_RD = 3,
   parameter int          P_PWR_NS  = 60,
   parameter logic [15:0] P_MFR     = 16'h005a, // Arbitrary value
   parameter logic [15:0] P_DEV     = 16'h00c3, // Arbitrary value
   parameter logic [15:0] P_CFI     = 16'h0051
) (
   // Flash pins
   input  wire fsps_pkg::fsps_pins_t pins,
   output logic [fsps_pkg::DW-1:0]   dq,
   output logic                      rdy_low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [logic [18:0]];
   logic [15:0] pr [8];
   logic [15:0] rv = 16'h0000;
   logic [18:0] pa = 19'h00000;
   logic [7:0]  code = 8'h00;
   logic        cfg = 0, lock = 0, susp = 0, fail = 0, tog = 0, t2 = 0, l7 = 0;
   int          step = 0, brd = 0, mode = 0;

   initial for (int i = 0; i < 8; i++) pr[i] = (i < 4) ? 16'h1000 + 16'(i) : 16'hffff;

   function automatic logic [15:0] mrd(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction

   // Open-drain ready: pulled low only while an internal cycle runs
   assign rdy_low = brd > 0 && !susp;
   // Released bus shows the inverse of the last value
   assign dq = (!pins.ce_n && !pins.oe_n) ? rv : ~rv;

   always @(negedge pins.we_n) begin
      if (!pins.ce_n && pins.oe_n) bus_wr(pins.addr, pins.dq);
   end

   always @(negedge pins.oe_n) begin
      if (!pins.ce_n) bus_rd(pins.addr);
   end

   task automatic bus_wr(input logic [18:0] a, input logic [15:0] d);
      logic [7:0] c;
      c = d[7:0];
      if (c == 8'hb0 && brd > 0) susp = 1;
      else if (c == 8'h30 && susp) susp = 0;
      else if (step == 3) fin(a, d);
      else if (step == 2) begin
         code = c;
         if (c == 8'h90 || c == 8'hf0) mode = (c == 8'h90) ? 1 : 0;
      end else if (c == 8'hf0) {mode, brd, fail} = '0;
      else if (a[11:0] == 12'h055 && c == 8'h98 && mode < 2) mode = 2;
      step = (step == 0 && a[11:0] == 12'h555 && c == 8'haa) ? 1 :
             (step == 1 && a[11:0] == 12'haaa && c == 8'h55) ? 2 :
             (step == 2 && c inside {8'ha0, 8'hc0, 8'hd0}) ? 3 : 0;
   endtask

   task automatic fin(input logic [18:0] a, input logic [15:0] d);
      if (code == 8'hd0) cfg = d[0];
      else if ($time >= P_PWR_NS) begin
         pa = a;
         l7 = d[7];
         brd = P_BUSY_RD;
         mode = 3;
         if (code == 8'ha0 && a[18]) fail = 1;
         else if (code == 8'ha0) mem[a] = mrd(a) & d;
         else if (a[7:0] == 8'h80) lock |= !d[1];
         else if (a[7:0] > 8'h84 && a[7:0] < 8'h89 && !lock) pr[a[2:0] - 3'h1] = d;
      end
   endtask

   task automatic bus_rd(input logic [18:0] a);
      if (susp && a[18:15] != pa[18:15]) rv = mrd(a);
      else if (susp) begin
         t2 = ~t2;
         rv = {8'h00, cfg | ~l7, 1'b1, 1'b0, 2'b00, t2, 2'b00};
      end else if (brd > 0 || fail) begin
         tog = ~tog;
         rv = {8'h00, ~cfg & ~l7, tog, fail, 2'b00, 1'b1, 2'b00};
         brd = (brd > 0) ? brd - 1 : 0;
         if (brd == 0 && !fail && !cfg) mode = 0;
      end else if (mode == 3) rv = {8'h00, 1'b1, tog, 6'b000100};
      else if (mode == 2) rv = P_CFI;
      else if (mode == 1 && a[7:0] < 8'h02) rv = a[0] ? P_DEV : P_MFR;
      else if (mode == 1 && a[7:0] == 8'h80) rv = {14'h0000, ~lock, 1'b0};
      else if (mode == 1 && a[7:0] > 8'h80 && a[7:0] < 8'h89) rv = pr[a[2:0] - 3'h1];
      else rv = mrd(a);
   endtask
endmodule // fsps_flash_model

// *** verif/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fsps_pkg::*;

   logic           clk = 1'b0, arst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
   logic [RAW-1:0] sw_addr = 5'h00;
   logic [31:0]    sw_wdata = 32'h0, sw_rdata, r;
   logic [31:0]    seed = 32'h0000bcc6;
   logic [31:0]    wl [$];
   logic [15:0]    em [int];
   logic [15:0]    idv [3] = '{16'h005a, 16'h00c3, 16'h1000};
   logic [DW-1:0]  m_dq, fl_dq;
   logic           m_low, fl_rdy;
   logic [18:0]    a;
   logic [15:0]    d;
   fsps_pins_t     fl_o;
   int             error_cnt = 0, checked = 0, polls = 0;

   always #2 clk = ~clk;
   assign fl_dq  = fl_o.dq_oe ? fl_o.dq : m_dq;
   assign fl_rdy = ~m_low;

   fsps_host #(.P_SUSP(16), .P_PWR(20)) i_dut (
      .clk(clk), .arst_n(arst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .fl_o(fl_o),
      .fl_dq_i(fl_dq), .fl_rdy_i(fl_rdy));
   fsps_flash_model i_flash (.pins(fl_o), .dq(m_dq), .rdy_low(m_low));

   always @(negedge fl_o.we_n) begin
      chk({29'h0, fl_o.dq_oe, fl_o.ce_n, fl_o.oe_n}, 32'h5);
      wl.push_back({fl_o.addr[11:0], 12'h000, fl_o.dq[7:0]});
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_wr(input int i, input logic [11:0] wa, input logic [7:0] wd);
      chk(wl[(i < 0) ? wl.size() - 1 : i], {wa, 12'h000, wd});
   endtask

   task automatic wr(input logic [4:0] ra, input logic [31:0] wd);
      @(posedge clk);
      sw_addr <= ra;
      sw_wdata <= wd;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] ra, output logic [31:0] rdv);
      @(posedge clk);
      sw_addr <= ra;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      rdv = sw_rdata;
   endtask

   task automatic cmd(input logic [3:0] c, input logic [18:0] fa, input logic [31:0] wd);
      wr(R_ADDR, {13'h0, fa});
      wr(R_WDATA, wd);
      wl.delete();
      wr(R_CTRL, {28'h0, c});
      for (polls = 1; polls < 4000; polls++) begin
         rd(R_STAT, r);
         if (r[ST_BUSY] === 1'b0) break;
      end
      if (polls == 4000) begin
         error_cnt++;
         $display("MISMATCH %0t busy never cleared", $time);
         print_verdict();
      end
   endtask

   task automatic rd_flash(input logic [18:0] fa);
      cmd(4'h0, fa, 32'h0);
      rd(R_RDATA, r);
   endtask

   task automatic print_verdict();
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      chk({sw_rdata[30:0], fl_o.ce_n}, 32'h1);
      arst_n <= 1'b1;
      cmd(4'h1, 19'h00010, 32'h1234);
      chk({24'h0, r[7:0]} & 32'h44, 32'h04);
      chk(32'(wl.size()), 32'h0);
      repeat (30) @(posedge clk);
      rd(R_STAT, r);
      chk({31'h0, r[ST_PWR]}, 32'h1);
      // Programs, the later ones with status configuration 01
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            cmd(4'h9, 19'h0, 32'h1);
            chk({31'h0, r[ST_CFG]}, 32'h1);
         end
         r = rnd();
         a = {7'h00, r[27:16]};
         d = r[15:0];
         em[a] = (em.exists(a) ? em[a] : 16'hffff) & d;
         cmd(4'h1, a, {16'h0, d});
         chk({30'h0, r[ST_FAIL], r[ST_RDY]}, 32'h1);
         chk_wr(2, 12'h555, 8'ha0);
         chk_wr(3, a[11:0], d[7:0]);
         if (k > 1) chk_wr(-1, 12'h000, 8'hf0);
         rd_flash(a);
         chk(r, {16'h0, em[a]});
      end
      // Program into a protected sector
      cmd(4'h1, 19'h40020, 32'h0);
      chk({31'h0, r[ST_FAIL]}, 32'h1);
      chk_wr(-1, 12'h000, 8'hf0);
      rd_flash(19'h40020);
      chk(r, 32'h0000ffff);
      // Query mode from read state, then from identification mode
      for (int k = 0; k < 2; k++) begin
         if (k == 1) cmd(4'h4, 19'h0, 32'h0);
         cmd(4'ha, 19'h0, 32'h0);
         chk_wr(0, 12'h055, 8'h98);
         rd_flash(a);
         chk(r, 32'h00000051);
         cmd(4'h5, 19'h0, 32'h0);
         rd_flash(a);
         chk(r, {16'h0, em[a]});
      end
      cmd(4'h4, 19'h0, 32'h0);
      chk_wr(2, 12'h555, 8'h90);
      for (int k = 0; k < 3; k++) begin
         rd_flash((k == 2) ? 19'h00081 : 19'(k));
         chk(r, {16'h0, idv[k]});
      end
      cmd(4'h5, 19'h0, 32'h0);
      // Protection register
      cmd(4'h6, 19'h00082, 32'h0);
      chk({31'h0, r[ST_REF]}, 32'h1);
      r = rnd();
      d = r[15:0];
      cmd(4'h6, 19'h00085, {16'h0, d});
      chk({31'h0, r[ST_REF]}, 32'h0);
      chk_wr(2, 12'h555, 8'hc0);
      chk_wr(3, 12'h085, d[7:0]);
      cmd(4'h8, 19'h0, 32'h0);
      chk({31'h0, r[ST_LOCK]}, 32'h0);
      cmd(4'h4, 19'h0, 32'h0);
      rd_flash(19'h00085);
      chk(r, {16'h0, d});
      cmd(4'h5, 19'h0, 32'h0);
      cmd(4'h7, 19'h0, 32'h0);
      chk(wl[3] & 32'hfff00002, 32'h08000000);
      cmd(4'h8, 19'h0, 32'h0);
      chk({31'h0, r[ST_LOCK]}, 32'h1);
      // Suspend and resume
      cmd(4'h2, 19'h0, 32'h0);
      chk({31'h0, polls >= 8 && polls <= 40}, 32'h1);
      chk(wl[0] & 32'hff, 32'hb0);
      cmd(4'h3, 19'h0, 32'h0);
      chk(wl[0] & 32'hff, 32'h30);
      rd(5'h14, r);
      chk(r, 32'h0);
      print_verdict();
   end
endmodule // tb_top
